/* File: src/acp_pkg.sv */
/*
 Constants, register map and types for the accelerometer I2C register port.
 Assumes a 20 MHz system clock and I2C pins already synchronous to it.
*/
// Summary of operation
// - Read opens with address plus write, then pointer
// - Repeated start, address plus read follows pointer
// - Acknowledge read address, send pointed register
// - Pointer advances after every byte read
// - Register bytes leave most significant bit first
// - Target stretches clock until read byte is ready
// - Single write: address, pointer, data, stop
// - Further write bytes land at next registers
// - Twenty registers in 8-bit space, rest reserved
// - Resolution bit selects 12 or 8 valid bits
// - Axis outputs refresh once per rate period
// - No new sample overwrites outputs during reads
// - Outputs are saturated two's-complement values
// - 12-bit counts: 1, 2, 4 mg per range
// - 8-bit counts: 16, 32, 64 mg per range
// - Target address is 000111 plus strap bit
// - Low byte bits 7:4 hold result 3:0
package acp_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFS_ACCEL_X_LOW = 8'h06;
	localparam logic [7:0] OFS_ACCEL_X_HIGH = 8'h07;
	localparam logic [7:0] OFS_ACCEL_Y_LOW = 8'h08;
	localparam logic [7:0] OFS_ACCEL_Y_HIGH = 8'h09;
	localparam logic [7:0] OFS_ACCEL_Z_LOW = 8'h0a;
	localparam logic [7:0] OFS_ACCEL_Z_HIGH = 8'h0b;
	localparam logic [7:0] OFS_COMM_CHECK_RESPONSE = 8'h0c;
	localparam logic [7:0] OFS_PART_IDENTITY = 8'h0f;
	localparam logic [7:0] OFS_EVENT_SOURCE_PRIMARY = 8'h16;
	localparam logic [7:0] OFS_MOTION_DIRECTION_SOURCE = 8'h17;
	localparam logic [7:0] OFS_EVENT_SUMMARY = 8'h18;
	localparam logic [7:0] OFS_EVENT_RELEASE = 8'h1a;
	localparam logic [7:0] OFS_CONTROL_PRIMARY = 8'h1b;
	localparam logic [7:0] OFS_CONTROL_SECONDARY = 8'h1d;
	localparam logic [7:0] OFS_EVENT_PIN_CONTROL = 8'h1e;
	localparam logic [7:0] OFS_EVENT_AXIS_CONTROL = 8'h1f;
	localparam logic [7:0] OFS_OUTPUT_RATE_CONTROL = 8'h21;
	localparam logic [7:0] OFS_MOTION_DELAY_COUNT = 8'h29;
	localparam logic [7:0] OFS_SELFTEST_CONTROL = 8'h3a;
	localparam logic [7:0] OFS_MOTION_THRESHOLD = 8'h6a;
	// ==========================================================
	// Storage slots of the writable registers
	localparam logic [2:0] IDX_CONTROL_SECONDARY = 3'h0;
	localparam logic [2:0] IDX_EVENT_PIN_CONTROL = 3'h1;
	localparam logic [2:0] IDX_EVENT_AXIS_CONTROL = 3'h2;
	localparam logic [2:0] IDX_MOTION_DELAY_COUNT = 3'h3;
	localparam logic [2:0] IDX_SELFTEST_CONTROL = 3'h4;
	localparam logic [2:0] IDX_MOTION_THRESHOLD = 3'h5;
	localparam logic [2:0] IDX_CONTROL_PRIMARY = 3'h6;
	localparam logic [2:0] IDX_OUTPUT_RATE_CONTROL = 3'h7;
	// ==========================================================
	// Fields and values
	localparam int CTRL_OPERATE_BIT = 7;
	localparam int CTRL_RES_BIT = 6;
	localparam int CTRL_GSEL_LSB = 3;
	localparam int RATE_CODE_LSB = 0;
	localparam int SRC_DRDY_BIT = 4;
	localparam int SUM_INT_BIT = 4;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] COMM_CHECK_VALUE = 8'h55;
	localparam logic [7:0] RESERVED_VALUE = 8'h00;
	localparam logic [5:0] TARGET_ADDR_FIXED = 6'h07;
	localparam int SHIFT_BASE = 2;
	localparam logic signed [11:0] OUT_MAX = 12'sh7ff;
	localparam logic signed [11:0] OUT_MIN = -12'sh800;
	// ==========================================================
	// Timing
	localparam int CLK_MHZ = 20;
	localparam int RATE_BASE_US = 1250;
	localparam int RATE_BASE_CYCLES = RATE_BASE_US * CLK_MHZ;
	localparam logic [1:0] STALE_CYCLES = 2'h2;
	// ==========================================================
	// Port state machine
	typedef enum logic [3:0] {
		ACP_IDLE, ACP_ADDR, ACP_ACK_ADDR, ACP_PTR, ACP_ACK_PTR,
		ACP_WDATA, ACP_ACK_W, ACP_RDATA, ACP_RACK
	} acp_state_t;
endpackage : acp_pkg

/* File: src/acp_cfg_ram.sv */
/*
 Small storage for the writable configuration registers, registered read.
 Assumes the caller tolerates one cycle of read latency.
*/
`timescale 1ns/1ps
module acp_cfg_ram import acp_pkg::*; #(
	parameter int AW = 3,
	parameter int DW = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Write side
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	// Read side
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [2**AW];

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < 2**AW; i++)
				mem[i] <= DW'(CFG_RESET);
			rdata <= '0;
		end
		else
		begin
			if (we)
				mem[waddr] <= wdata;
			rdata <= mem[raddr];
		end
	end
endmodule : acp_cfg_ram

/* File: src/acp_register_port.sv */
/*
 I2C target port and register file of a three-axis accelerometer.
 Assumes SCL and SDA are already synchronous to clk and open-drain outside.
*/
`timescale 1ns/1ps
module acp_register_port import acp_pkg::*; #(
	parameter int RATE_BASE = RATE_BASE_CYCLES,
	parameter logic [7:0] IDENTITY_VALUE = 8'h5a // Arbitrary value
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// I2C pins
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Address strap
	input wire logic addr_select,
	// Sensing path, 0.25 mg per count
	input wire logic signed [15:0] raw_x,
	input wire logic signed [15:0] raw_y,
	input wire logic signed [15:0] raw_z,
	// Configuration to sensing path
	output logic operate_enable,
	output logic [2:0] output_rate
);
	// ==========================================================
	// Bus conditions
	logic scl_q, sda_q;
	wire scl_rise = scl_in & ~scl_q;
	wire scl_fall = ~scl_in & scl_q;
	wire start_cond = scl_in & scl_q & sda_q & ~sda_in;
	wire stop_cond = scl_in & scl_q & ~sda_q & sda_in;

	acp_state_t state, next_state;
	logic [3:0] cnt, next_cnt;
	logic [7:0] rx, next_rx;
	logic [7:0] tx, next_tx;
	logic [7:0] ptr, next_ptr;
	logic drive_low, next_drive_low;
	logic load_pending, next_load_pending;
	logic read_lock, next_read_lock;
	logic mack, next_mack;
	logic [1:0] stale;
	logic strap, strap_taken;
	logic [7:0] ctrl_q, rate_q;
	logic drdy, refresh_due;
	logic [23:0] rate_cnt;
	logic [7:0] out_low [3];
	logic [7:0] out_high [3];
	logic [7:0] ram_q;

	wire byte_done = (cnt == 4'h8);
	wire addr_match = (rx[7:1] == {TARGET_ADDR_FIXED, strap});
	wire load_go = load_pending & (stale == 2'h0);
	wire wr_strobe = scl_fall & (state == ACP_WDATA) & byte_done;
	wire rx_state = (state == ACP_ADDR) | (state == ACP_PTR) | (state == ACP_WDATA);

	// ==========================================================
	// Register decode
	function automatic logic [3:0] cfg_slot(input logic [7:0] a);
		case (a)
			OFS_CONTROL_SECONDARY: cfg_slot = {1'b1, IDX_CONTROL_SECONDARY};
			OFS_EVENT_PIN_CONTROL: cfg_slot = {1'b1, IDX_EVENT_PIN_CONTROL};
			OFS_EVENT_AXIS_CONTROL: cfg_slot = {1'b1, IDX_EVENT_AXIS_CONTROL};
			OFS_MOTION_DELAY_COUNT: cfg_slot = {1'b1, IDX_MOTION_DELAY_COUNT};
			OFS_SELFTEST_CONTROL: cfg_slot = {1'b1, IDX_SELFTEST_CONTROL};
			OFS_MOTION_THRESHOLD: cfg_slot = {1'b1, IDX_MOTION_THRESHOLD};
			OFS_CONTROL_PRIMARY: cfg_slot = {1'b1, IDX_CONTROL_PRIMARY};
			OFS_OUTPUT_RATE_CONTROL: cfg_slot = {1'b1, IDX_OUTPUT_RATE_CONTROL};
			default: cfg_slot = 4'h0;
		endcase
	endfunction : cfg_slot

	wire [3:0] slot = cfg_slot(ptr);
	wire cfg_hit = slot[3];
	wire ram_we = wr_strobe & cfg_hit;
	wire [7:0] drdy_byte = {3'h0, drdy, 4'h0};
	wire [7:0] ro_value =
		(ptr == OFS_ACCEL_X_LOW) ? out_low[0] :
		(ptr == OFS_ACCEL_X_HIGH) ? out_high[0] :
		(ptr == OFS_ACCEL_Y_LOW) ? out_low[1] :
		(ptr == OFS_ACCEL_Y_HIGH) ? out_high[1] :
		(ptr == OFS_ACCEL_Z_LOW) ? out_low[2] :
		(ptr == OFS_ACCEL_Z_HIGH) ? out_high[2] :
		(ptr == OFS_COMM_CHECK_RESPONSE) ? COMM_CHECK_VALUE :
		(ptr == OFS_PART_IDENTITY) ? IDENTITY_VALUE :
		(ptr == OFS_EVENT_SOURCE_PRIMARY) ? drdy_byte :
		(ptr == OFS_EVENT_SUMMARY) ? drdy_byte : RESERVED_VALUE;
	wire [7:0] read_value = cfg_hit ? ram_q : ro_value;
	wire out_read = (ptr >= OFS_ACCEL_X_LOW) & (ptr <= OFS_ACCEL_Z_HIGH);
	wire drdy_clear = load_go & (out_read | (ptr == OFS_EVENT_RELEASE));

	acp_cfg_ram #(.AW(3), .DW(8)) u_cfg_ram (
		.clk(clk),
		.rst_n(rst_n),
		.we(ram_we),
		.waddr(slot[2:0]),
		.wdata(rx),
		.raddr(slot[2:0]),
		.rdata(ram_q)
	);

	// ==========================================================
	// Port state machine
	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_rx = rx;
		next_tx = tx;
		next_ptr = ptr;
		next_drive_low = drive_low;
		next_load_pending = load_pending;
		next_read_lock = read_lock;
		next_mack = mack;
		if (start_cond | stop_cond)
		begin
			next_state = start_cond ? ACP_ADDR : ACP_IDLE;
			next_cnt = 4'h0;
			next_drive_low = 1'b0;
			next_load_pending = 1'b0;
			next_read_lock = 1'b0;
		end
		else if (load_go)
		begin
			next_tx = read_value;
			next_drive_low = ~read_value[7];
			next_load_pending = 1'b0;
		end
		else if (scl_rise)
		begin
			if (rx_state & ~byte_done)
			begin
				next_rx = {rx[6:0], sda_in};
				next_cnt = cnt + 4'h1;
			end
			else if ((state == ACP_RDATA) & ~byte_done)
				next_cnt = cnt + 4'h1;
			else if (state == ACP_RACK)
				next_mack = ~sda_in;
		end
		else if (scl_fall)
		begin
			case (state)
				ACP_ADDR:
					if (byte_done)
					begin
						next_state = addr_match ? ACP_ACK_ADDR : ACP_IDLE;
						next_drive_low = addr_match;
					end
				ACP_PTR:
					if (byte_done)
					begin
						next_ptr = rx;
						next_state = ACP_ACK_PTR;
						next_drive_low = 1'b1;
					end
				ACP_WDATA:
					if (byte_done)
					begin
						next_ptr = ptr + 8'h01;
						next_state = ACP_ACK_W;
						next_drive_low = 1'b1;
					end
				ACP_ACK_ADDR:
				begin
					next_drive_low = 1'b0;
					next_cnt = 4'h0;
					next_state = rx[0] ? ACP_RDATA : ACP_PTR;
					next_load_pending = rx[0];
					next_read_lock = rx[0];
				end
				ACP_ACK_PTR, ACP_ACK_W:
				begin
					next_drive_low = 1'b0;
					next_cnt = 4'h0;
					next_state = ACP_WDATA;
				end
				ACP_RDATA:
					if (byte_done)
					begin
						next_drive_low = 1'b0;
						next_ptr = ptr + 8'h01;
						next_state = ACP_RACK;
					end
					else
					begin
						next_tx = {tx[6:0], 1'b0};
						next_drive_low = ~tx[6];
					end
				ACP_RACK:
				begin
					next_cnt = 4'h0;
					next_state = mack ? ACP_RDATA : ACP_IDLE;
					next_load_pending = mack;
				end
				default: next_state = ACP_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ACP_IDLE;
			cnt <= 4'h0;
			rx <= 8'h00;
			tx <= 8'h00;
			ptr <= 8'h00;
			drive_low <= 1'b0;
			load_pending <= 1'b0;
			read_lock <= 1'b0;
			mack <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			rx <= next_rx;
			tx <= next_tx;
			ptr <= next_ptr;
			drive_low <= next_drive_low;
			load_pending <= next_load_pending;
			read_lock <= next_read_lock;
			mack <= next_mack;
		end
	end

	// ==========================================================
	// Pins, strap and read-data freshness
	// Stretching only while a byte is fetched keeps the wait to a few cycles
	assign scl_oe = load_pending;
	assign scl_out = 1'b0;
	assign sda_oe = drive_low;
	assign sda_out = 1'b0;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			strap <= 1'b0;
			strap_taken <= 1'b0;
			stale <= STALE_CYCLES;
		end
		else
		begin
			scl_q <= scl_in;
			sda_q <= sda_in;
			strap_taken <= 1'b1;
			if (!strap_taken)
				strap <= addr_select;
			// Storage answers a cycle late, so wait two after any pointer move
			stale <= (next_ptr != ptr) ? STALE_CYCLES : (stale - {1'b0, stale != 2'h0});
		end
	end

	// ==========================================================
	// Configuration shadows
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_q <= CFG_RESET;
			rate_q <= CFG_RESET;
		end
		else if (ram_we)
		begin
			if (slot[2:0] == IDX_CONTROL_PRIMARY)
				ctrl_q <= rx;
			if (slot[2:0] == IDX_OUTPUT_RATE_CONTROL)
				rate_q <= rx;
		end
	end

	assign operate_enable = ctrl_q[CTRL_OPERATE_BIT];
	assign output_rate = rate_q[RATE_CODE_LSB +: 3];
	wire res_sel = ctrl_q[CTRL_RES_BIT];
	wire [1:0] gsel = ctrl_q[CTRL_GSEL_LSB +: 2];

	// ==========================================================
	// Output rate timer and sample refresh
	wire [23:0] period = 24'(RATE_BASE) << output_rate;
	wire rate_hit = operate_enable & (rate_cnt >= period - 24'h1);
	// A sample due during a read waits, trading latency for coherence
	wire refresh_take = refresh_due & ~read_lock;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rate_cnt <= 24'h0;
			refresh_due <= 1'b0;
			drdy <= 1'b0;
		end
		else
		begin
			rate_cnt <= (rate_hit | ~operate_enable) ? 24'h0 : rate_cnt + 24'h1;
			refresh_due <= rate_hit | (refresh_due & read_lock);
			drdy <= refresh_take | (drdy & ~drdy_clear);
		end
	end

	function automatic logic signed [11:0] scale(input logic signed [15:0] raw, input logic [1:0] g,
		input logic res);
		logic signed [15:0] sh;
		logic signed [11:0] v;
		sh = raw >>> (SHIFT_BASE + ((g == 2'h3) ? 2 : int'(g)));
		v = (sh > 16'(OUT_MAX)) ? OUT_MAX : (sh < 16'(OUT_MIN)) ? OUT_MIN : sh[11:0];
		scale = res ? v : {v[11:4], 4'h0};
	endfunction : scale

	wire logic signed [15:0] raw_all [3];
	assign raw_all[0] = raw_x;
	assign raw_all[1] = raw_y;
	assign raw_all[2] = raw_z;

	for (genvar a = 0; a < 3; a++)
	begin : g_axis
		wire logic signed [11:0] val = scale(raw_all[a], gsel, res_sel);
		always_ff @(posedge clk or negedge rst_n)
		begin
			if (!rst_n)
			begin
				out_low[a] <= 8'h00;
				out_high[a] <= 8'h00;
			end
			else if (refresh_take)
			begin
				out_low[a] <= {val[3:0], 4'h0};
				// In 8-bit mode the scaled value already has its low nibble cleared
				out_high[a] <= val[11:4];
			end
		end
	end

	// ==========================================================
	// Checks
	a_ack_match: assert property (@(posedge clk) disable iff (!rst_n)
		scl_fall && state == ACP_ADDR && byte_done && addr_match |=> sda_oe && state == ACP_ACK_ADDR)
		else $error("matching address not acknowledged");
	a_msb_first: assert property (@(posedge clk) disable iff (!rst_n)
		load_go && !start_cond && !stop_cond |=> sda_oe == !$past(read_value[7]) && tx == $past(read_value))
		else $error("first bit sent is not the top bit");
	a_ro_write: assert property (@(posedge clk) disable iff (!rst_n)
		wr_strobe && !cfg_hit |=> $stable(ctrl_q) && $stable(rate_q) && state == ACP_ACK_W && sda_oe)
		else $error("read-only write changed state or was not acknowledged");
	a_lock_hold: assert property (@(posedge clk) disable iff (!rst_n)
		read_lock |=> $stable(out_high[0]) && $stable(out_low[0]) || !$past(read_lock))
		else $error("outputs changed during a read");
	a_ptr_write: assert property (@(posedge clk) disable iff (!rst_n)
		wr_strobe && !start_cond && !stop_cond |=> ptr == $past(ptr) + 8'h01)
		else $error("pointer did not advance after a write byte");
	a_nack_free: assert property (@(posedge clk) disable iff (!rst_n)
		scl_fall && state == ACP_RACK && !mack && !start_cond |=> (!sda_oe && state == ACP_IDLE) [*2])
		else $error("data still driven after nack");
	a_stretch_end: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(load_pending) |-> ##[1:4] !scl_oe)
		else $error("clock stretch too long");
	a_refresh: assert property (@(posedge clk) disable iff (!rst_n)
		rate_hit && !read_lock ##1 !read_lock |=> drdy)
		else $error("rate period passed without a refresh");
	a_scale_12: assert property (@(posedge clk) disable iff (!rst_n)
		refresh_take && res_sel && gsel == 2'h1 && raw_x == 16'sh0008 |=> out_high[0] == 8'h00 && out_low[0] == 8'h10)
		else $error("12-bit scaling wrong");
	a_scale_8: assert property (@(posedge clk) disable iff (!rst_n)
		refresh_take && !res_sel && gsel == 2'h0 && raw_x == -16'sh0040 |=> out_high[0] == 8'hff && out_low[0] == 8'h00)
		else $error("8-bit scaling wrong");
	c_write: cover property (@(posedge clk) disable iff (!rst_n) ram_we);
	c_multi_read: cover property (@(posedge clk) disable iff (!rst_n) scl_fall && state == ACP_RACK && mack);
	c_stretch: cover property (@(posedge clk) disable iff (!rst_n) scl_oe ##1 scl_oe);
	c_deferred: cover property (@(posedge clk) disable iff (!rst_n) refresh_due && read_lock);
endmodule : acp_register_port

/* File: testbench/acp_i2c_ctrl_model.sv */
/*
 Behavioural I2C controller that drives SCL and SDA as open-drain pulls.
 Assumes the bench resolves both wires with pull-ups and feeds the levels back.
*/
`timescale 1ns/1ps
module acp_i2c_ctrl_model #(
	parameter int HALF = 4
) (
	// Clock and resolved wires
	input wire logic clk,
	input wire logic scl_line,
	input wire logic sda_line,
	// Open-drain pulls
	output logic scl_low,
	output logic sda_low
);
	// ====================
	// Bus primitives
	initial
	begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end

	task automatic pause();
		repeat (HALF) @(negedge clk);
	endtask : pause

	// Bounded wait, so a stuck stretch shows as bad data rather than a hang
	task automatic scl_up();
		int n;
		scl_low <= 1'b0;
		for (n = 0; n < 400 && scl_line !== 1'b1; n++)
			@(negedge clk);
		pause();
	endtask : scl_up

	task automatic bit_out(input logic b);
		sda_low <= ~b;
		pause();
		scl_up();
		scl_low <= 1'b1;
		pause();
	endtask : bit_out

	task automatic bit_in(output logic b);
		sda_low <= 1'b0;
		pause();
		scl_up();
		b = sda_line;
		scl_low <= 1'b1;
		pause();
	endtask : bit_in

	// Start and repeated start share one shape
	task automatic start();
		sda_low <= 1'b0;
		pause();
		scl_up();
		sda_low <= 1'b1;
		pause();
		scl_low <= 1'b1;
		pause();
	endtask : start

	task automatic stop();
		sda_low <= 1'b1;
		pause();
		scl_up();
		sda_low <= 1'b0;
		pause();
	endtask : stop

	task automatic write_byte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--)
			bit_out(d[i]);
		bit_in(b);
		ack = ~b;
	endtask : write_byte

	// Every byte but the last is acknowledged
	task automatic read_byte(input logic last, output logic [7:0] d);
		for (int i = 7; i >= 0; i--)
			bit_in(d[i]);
		bit_out(last);
	endtask : read_byte
endmodule : acp_i2c_ctrl_model

/* File: testbench/acp_register_port_tb_top.sv */
/*
 Self-checking bench for the accelerometer register port.
 Assumes acp_i2c_ctrl_model as bus controller and pull-ups on SCL and SDA.
*/
`timescale 1ns/1ps
module acp_register_port_tb_top import acp_pkg::*;;
	// ====================
	// Signals
	localparam logic [7:0] ID_VAL = 8'h3c; // Arbitrary value
	localparam logic [6:0] DEV = {TARGET_ADDR_FIXED, 1'b0}; // Strap tied low
	logic clk;
	logic rst_n;
	logic addr_select;
	logic signed [15:0] raw_x;
	logic signed [15:0] raw_y;
	logic signed [15:0] raw_z;
	logic scl_out;
	logic scl_oe;
	logic sda_out;
	logic sda_oe;
	logic operate_enable;
	logic [2:0] output_rate;
	logic m_scl_low;
	logic m_sda_low;
	wire scl_line = ~(m_scl_low | (scl_oe & ~scl_out));
	wire sda_line = ~(m_sda_low | (sda_oe & ~sda_out));
	int num_errors = 0;
	int compares = 0;
	logic [31:0] seed = 32'he2e7d9aa;
	logic [31:0] r;
	logic [7:0] shadow [256];
	logic [7:0] wq [$];
	logic [7:0] rq [$];
	logic [7:0] pick [13] = '{8'h1b, 8'h1d, 8'h1e, 8'h1f, 8'h21, 8'h29, 8'h3a, 8'h6a, 8'h0c, 8'h0f, 8'h00, 8'h1c, 8'h7f};
	logic signed [15:0] cur_raw [3];
	logic signed [15:0] next_raw [3];
	logic mid_swap;
	logic saw_stretch;
	logic ack;
	logic res;
	logic [1:0] rng;

	acp_register_port #(.RATE_BASE(16), .IDENTITY_VALUE(ID_VAL)) u_acp_register_port (
		.clk(clk), .rst_n(rst_n), .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .addr_select(addr_select),
		.raw_x(raw_x), .raw_y(raw_y), .raw_z(raw_z), .operate_enable(operate_enable), .output_rate(output_rate)
	);
	acp_i2c_ctrl_model u_acp_i2c_ctrl_model (
		.clk(clk), .scl_line(scl_line), .sda_line(sda_line), .scl_low(m_scl_low), .sda_low(m_sda_low)
	);

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk)
		if (scl_oe === 1'b1)
			saw_stretch <= 1'b1;

	initial
	begin
		repeat (100000) @(posedge clk);
		num_errors++;
		final_report();
	end

	// ====================
	// Helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	function automatic logic is_rw(input logic [7:0] a);
		return a inside {8'h1b, 8'h1d, 8'h1e, 8'h1f, 8'h21, 8'h29, 8'h3a, 8'h6a};
	endfunction : is_rw

	// Raw input counts 0.25 mg, so range code adds to the shift
	function automatic logic [7:0] axis_byte(input logic signed [15:0] raw, input logic [1:0] rg, input logic rs,
		input logic hi);
		logic signed [15:0] s;
		logic [11:0] v;
		s = raw >>> (2 + rg);
		v = (s > 16'sh07ff) ? 12'h7ff : (s < -16'sh0800) ? 12'h800 : s[11:0];
		if (hi)
			return v[11:4];
		return rs ? {v[3:0], 4'h0} : 8'h00;
	endfunction : axis_byte

	task automatic check_val(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check_val

	task automatic final_report();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report

	task automatic xfer_write(input logic [7:0] ptr);
		u_acp_i2c_ctrl_model.start();
		u_acp_i2c_ctrl_model.write_byte({DEV, 1'b0}, ack);
		check_val({7'h0, ack}, 8'h01);
		u_acp_i2c_ctrl_model.write_byte(ptr & 8'h7f, ack);
		check_val({7'h0, ack}, 8'h01);
		foreach (wq[i])
		begin
			u_acp_i2c_ctrl_model.write_byte(wq[i], ack);
			check_val({7'h0, ack}, 8'h01);
			if (is_rw(8'(ptr + i)))
				shadow[8'(ptr + i)] = wq[i];
		end
		u_acp_i2c_ctrl_model.stop();
	endtask : xfer_write

	task automatic xfer_read(input logic [7:0] ptr, input int n);
		logic [7:0] d;
		rq.delete();
		u_acp_i2c_ctrl_model.start();
		u_acp_i2c_ctrl_model.write_byte({DEV, 1'b0}, ack);
		u_acp_i2c_ctrl_model.write_byte(ptr, ack);
		check_val({7'h0, ack}, 8'h01);
		u_acp_i2c_ctrl_model.start();
		u_acp_i2c_ctrl_model.write_byte({DEV, 1'b1}, ack);
		check_val({7'h0, ack}, 8'h01);
		for (int i = 0; i < n; i++)
		begin
			u_acp_i2c_ctrl_model.read_byte(i == n - 1, d);
			rq.push_back(d);
			if (mid_swap && i == 0)
			begin
				raw_x = next_raw[0];
				raw_y = next_raw[1];
				raw_z = next_raw[2];
			end
		end
		u_acp_i2c_ctrl_model.stop();
		check_val({7'h0, sda_oe}, 8'h00);
	endtask : xfer_read

	task automatic rd_cmp(input logic [7:0] ptr, input int n);
		xfer_read(ptr, n);
		foreach (rq[i])
			check_val(rq[i], shadow[8'(ptr + i)]);
	endtask : rd_cmp

	// ====================
	// Main sequence
	initial
	begin
		rst_n = 1'b0;
		addr_select = 1'b0;
		raw_x = 16'sh0000;
		raw_y = 16'sh0000;
		raw_z = 16'sh0000;
		mid_swap = 1'b0;
		saw_stretch = 1'b0;
		foreach (shadow[i])
			shadow[i] = 8'h00;
		shadow[OFS_COMM_CHECK_RESPONSE] = COMM_CHECK_VALUE;
		shadow[OFS_PART_IDENTITY] = ID_VAL;
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		check_val({7'h0, operate_enable}, 8'h00);
		check_val({5'h0, output_rate}, 8'h00);
		rd_cmp(OFS_CONTROL_PRIMARY, 7);
		rd_cmp(OFS_COMM_CHECK_RESPONSE, 4);
		// Other strap value must stay unanswered
		u_acp_i2c_ctrl_model.start();
		u_acp_i2c_ctrl_model.write_byte({TARGET_ADDR_FIXED, 1'b1, 1'b0}, ack);
		check_val({7'h0, ack}, 8'h00);
		u_acp_i2c_ctrl_model.stop();
		// Operate enable stays clear while configuring
		for (int k = 0; k < 10; k++)
		begin
			r = rnd();
			wq.delete();
			wq.push_back((pick[r[3:0] % 13] == OFS_CONTROL_PRIMARY) ? (r[15:8] & 8'h7f) : r[15:8]);
			if (r[16])
				wq.push_back(r[31:24]);
			xfer_write(pick[r[3:0] % 13]);
			rd_cmp(pick[r[3:0] % 13], 2);
			check_val({7'h0, operate_enable}, {7'h0, shadow[OFS_CONTROL_PRIMARY][CTRL_OPERATE_BIT]});
			check_val({5'h0, output_rate}, {5'h0, shadow[OFS_OUTPUT_RATE_CONTROL][2:0]});
		end
		wq = '{8'h00};
		xfer_write(OFS_OUTPUT_RATE_CONTROL);
		for (int c = 0; c < 6; c++)
		begin
			res = c[0];
			rng = 2'(c / 2);
			wq = '{8'h00};
			xfer_write(OFS_CONTROL_PRIMARY);
			wq = '{{1'b1, res, 1'b0, rng, 3'h0}};
			xfer_write(OFS_CONTROL_PRIMARY);
			check_val({7'h0, operate_enable}, 8'h01);
			r = rnd();
			raw_x = r[15:0];
			raw_y = {{4{r[27]}}, r[27:16]};
			raw_z = (res ? 16'sh0004 : 16'sh0040) <<< rng;
			cur_raw = '{raw_x, raw_y, raw_z};
			next_raw = '{raw_y, raw_z, raw_x};
			for (int p = 0; p < 2; p++)
			begin
				repeat (40) @(negedge clk);
				mid_swap = (p == 0);
				xfer_read(OFS_ACCEL_X_LOW, 6);
				mid_swap = 1'b0;
				for (int j = 0; j < 6; j++)
					check_val(rq[j], axis_byte(p ? next_raw[j / 2] : cur_raw[j / 2], rng, res, j[0]));
			end
		end
		// Data ready shows in both event registers once a sample lands
		repeat (40) @(negedge clk);
		xfer_read(OFS_EVENT_SOURCE_PRIMARY, 3);
		check_val(rq[0], 8'(1 << SRC_DRDY_BIT));
		check_val(rq[1], RESERVED_VALUE);
		check_val(rq[2], 8'(1 << SUM_INT_BIT));
		check_val({7'h0, saw_stretch}, 8'h01);
		final_report();
	end
endmodule : acp_register_port_tb_top
